//--- inc/wdt_defines.vh
/*
 * Register offsets, field positions, reset values and timing counts for the windowed watchdog.
 * Assumes it is included by bare name from the watchdog design and bench files.
 */
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

`define ADDR_W 4
`define OFS_CONTROL 4'h0
`define OFS_TIMING_SETUP 4'h1
`define OFS_EARLY_WARNING_SETUP 4'h2
`define OFS_IRQ_ENABLE_OFF 4'h4
`define OFS_IRQ_ENABLE_ON 4'h5
`define OFS_IRQ_PENDING 4'h6
`define OFS_SYNC_STATE 4'h7
`define OFS_SERVICE_KEY 4'h8

`define CTRL_ENABLE_BIT 1
`define CTRL_WINDOW_BIT 2
`define CTRL_LOCK_BIT 7
`define EARLY_WARNING_BIT 0
`define SYNC_PENDING_BIT 7

`define RST_IRQ_ENABLE 1'b0
`define RST_IRQ_PENDING 1'b0
`define RST_BYTE 8'h00

`define SERVICE_KEY_VALUE 8'hA5

`define LEN_W 15
`define LEN_MIN 15'h0008
`define LEN_MAX 15'h4000
`define CODE_MAX 4'hB

`define SYNC_CYCLES 3'h4
`define SYNC_CNT_W 3

`endif

//--- logic/wdt_pin_sync.v
/*
 * Two-flop synchroniser for levels arriving from outside the system clock domain.
 * Assumes a free-running system clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps

module wdt_pin_sync #(
   parameter W = 1
) (
   input wire i_clk_sys,
   input wire i_rst_n,
   input wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);

   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   // first stage feeds only the second stage
   always @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         meta_r <= {W{1'b0}};
         sync_r <= {W{1'b0}};
      end
      else
      begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end

   assign o_sync = sync_r;

endmodule // wdt_pin_sync

//--- logic/wdt_len_decode.v
/*
 * Decodes a four-bit doubling code into a length in watchdog count clock ticks.
 * Assumes callers treat the returned length as the tick count that ends the interval.
 */
`timescale 1ns/100ps
`include "wdt_defines.vh"

module wdt_len_decode (
   input wire [3:0] i_code,
   output wire [`LEN_W-1:0] o_len
);

   wire [`LEN_W-1:0] base_len;

   assign base_len = `LEN_MIN;

   // reserved codes saturate to the longest interval rather than wrapping short
   assign o_len = (i_code > `CODE_MAX) ? `LEN_MAX : (base_len << i_code);

endmodule // wdt_len_decode

//--- logic/wdt_window_watchdog.v
/*
 * Windowed watchdog with byte-wide register port, keyed service, early warning and sync tracking.
 * Assumes the count clock arrives as a slow pin level, and the startup values come from the
 * nonvolatile configuration row and are stable when reset is released.
 */
`timescale 1ns/100ps
`include "wdt_defines.vh"

module wdt_window_watchdog (
   input wire i_clk_sys,
   input wire i_rst_n,
   input wire i_watchdog_count_clock,
   input wire [7:0] i_cfg_row_control,
   input wire [7:0] i_cfg_row_timing,
   input wire [7:0] i_cfg_row_early_warning,
   input wire [`ADDR_W-1:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   output reg o_irq,
   output reg o_sys_reset,
   output reg o_sync_pending
);

   reg startup_load_r;
   reg enable_r;
   reg window_en_r;
   reg permanent_run_lock_r;
   reg [3:0] window_select_r;
   reg [3:0] timeout_period_select_r;
   reg [3:0] early_warning_offset_r;
   reg irq_enable_r;
   reg early_warning_bit_r;
   reg sync_busy_r;
   reg [`SYNC_CNT_W-1:0] sync_cnt_r;
   reg held_valid_r;
   reg [`ADDR_W-1:0] held_addr_r;
   reg [7:0] held_data_r;
   reg tick_prev_r;
   reg [`LEN_W-1:0] count_r;
   reg open_phase_r;

   reg [7:0] rdata_nxt;
   reg [`LEN_W-1:0] count_nxt;
   reg open_phase_nxt;
   reg early_warning_event;
   reg timeout_event;

   wire tick_level;
   wire tick;
   wire [`LEN_W-1:0] closed_len;
   wire [`LEN_W-1:0] period_len;
   wire [`LEN_W-1:0] offset_len;
   wire [`LEN_W-1:0] count_inc;
   wire bus_sync_wr;
   wire sync_issue;
   wire [`ADDR_W-1:0] sync_addr;
   wire [7:0] sync_data;
   wire running;
   wire setup_writable;
   wire service_write;
   wire service_good;
   wire service_bad;
   wire closed_window_service;
   wire wr_enable_off;
   wire wr_enable_on;
   wire wr_pending_clear;
   wire sync_done;

   // count clock is a slow foreign level; its rising edge becomes a one-cycle tick
   wdt_pin_sync #(
      .W(1)
   ) u_tick_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_async(i_watchdog_count_clock),
      .o_sync(tick_level)
   );

   assign tick = tick_level & ~tick_prev_r;

   wdt_len_decode u_closed_len (
      .i_code(window_select_r),
      .o_len(closed_len)
   );

   wdt_len_decode u_period_len (
      .i_code(timeout_period_select_r),
      .o_len(period_len)
   );

   wdt_len_decode u_offset_len (
      .i_code(early_warning_offset_r),
      .o_len(offset_len)
   );

   assign count_inc = count_r + 15'h0001;

   // control, timing setup and service writes are the synchronised ones
   assign bus_sync_wr = i_wr & ((i_addr == `OFS_CONTROL) | (i_addr == `OFS_TIMING_SETUP) |
                               (i_addr == `OFS_SERVICE_KEY));

   // a held write always goes before a fresh one so program order is kept
   assign sync_issue = ~sync_busy_r & (held_valid_r | bus_sync_wr);
   assign sync_addr = held_valid_r ? held_addr_r : i_addr;
   assign sync_data = held_valid_r ? held_data_r : i_wdata;
   assign sync_done = sync_busy_r & (sync_cnt_r == {{(`SYNC_CNT_W-1){1'b0}}, 1'b1});

   assign running = enable_r | permanent_run_lock_r;
   // setup fields are also guarded while the watchdog runs, like the timing fields
   assign setup_writable = ~permanent_run_lock_r & ~enable_r;

   assign service_write = sync_issue & (sync_addr == `OFS_SERVICE_KEY);
   assign service_good = service_write & (sync_data == `SERVICE_KEY_VALUE);
   assign service_bad = service_write & (sync_data != `SERVICE_KEY_VALUE);
   assign closed_window_service = service_good & running & window_en_r & ~open_phase_r;

   assign wr_enable_off = i_wr & (i_addr == `OFS_IRQ_ENABLE_OFF) & i_wdata[`EARLY_WARNING_BIT];
   assign wr_enable_on = i_wr & (i_addr == `OFS_IRQ_ENABLE_ON) & i_wdata[`EARLY_WARNING_BIT];
   assign wr_pending_clear = i_wr & (i_addr == `OFS_IRQ_PENDING) & i_wdata[`EARLY_WARNING_BIT];

   // counting: normal mode runs one period, window mode a closed then an open phase
   always @*
   begin
      count_nxt = count_r;
      open_phase_nxt = open_phase_r;
      early_warning_event = 1'b0;
      timeout_event = 1'b0;
      if (!running)
      begin
         count_nxt = {`LEN_W{1'b0}};
         open_phase_nxt = 1'b0;
      end
      else if (service_good)
      begin
         count_nxt = {`LEN_W{1'b0}};
         open_phase_nxt = 1'b0;
      end
      else if (tick)
      begin
         count_nxt = count_inc;
         if (!window_en_r)
         begin
            if (count_inc == offset_len)
            begin
               early_warning_event = 1'b1;
            end
            if (count_inc == period_len)
            begin
               timeout_event = 1'b1;
               count_nxt = {`LEN_W{1'b0}};
            end
         end
         else if (!open_phase_r)
         begin
            if (count_inc == closed_len)
            begin
               open_phase_nxt = 1'b1;
               early_warning_event = 1'b1;
               count_nxt = {`LEN_W{1'b0}};
            end
         end
         else if (count_inc == period_len)
         begin
            timeout_event = 1'b1;
            open_phase_nxt = 1'b0;
            count_nxt = {`LEN_W{1'b0}};
         end
      end
   end

   // read mux, data shows in the cycle after the strobe
   always @*
   begin
      rdata_nxt = `RST_BYTE;
      case (i_addr)
         `OFS_CONTROL:
         begin
            rdata_nxt[`CTRL_LOCK_BIT] = permanent_run_lock_r;
            rdata_nxt[`CTRL_WINDOW_BIT] = window_en_r;
            rdata_nxt[`CTRL_ENABLE_BIT] = enable_r;
         end
         `OFS_TIMING_SETUP:
         begin
            rdata_nxt = {window_select_r, timeout_period_select_r};
         end
         `OFS_EARLY_WARNING_SETUP:
         begin
            rdata_nxt[3:0] = early_warning_offset_r;
         end
         `OFS_IRQ_ENABLE_OFF, `OFS_IRQ_ENABLE_ON:
         begin
            rdata_nxt[`EARLY_WARNING_BIT] = irq_enable_r;
         end
         `OFS_IRQ_PENDING:
         begin
            rdata_nxt[`EARLY_WARNING_BIT] = early_warning_bit_r;
         end
         `OFS_SYNC_STATE:
         begin
            rdata_nxt[`SYNC_PENDING_BIT] = sync_busy_r;
         end
         default:
         begin
            rdata_nxt = `RST_BYTE;
         end
      endcase
   end

   // configuration: the row is caught on the first edge after reset release
   always @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         startup_load_r <= 1'b1;
         enable_r <= 1'b0;
         window_en_r <= 1'b0;
         permanent_run_lock_r <= 1'b0;
         window_select_r <= 4'h0;
         timeout_period_select_r <= 4'h0;
         early_warning_offset_r <= 4'h0;
      end
      else if (startup_load_r)
      begin
         startup_load_r <= 1'b0;
         enable_r <= i_cfg_row_control[`CTRL_ENABLE_BIT];
         window_en_r <= i_cfg_row_control[`CTRL_WINDOW_BIT];
         permanent_run_lock_r <= i_cfg_row_control[`CTRL_LOCK_BIT];
         window_select_r <= i_cfg_row_timing[7:4];
         timeout_period_select_r <= i_cfg_row_timing[3:0];
         early_warning_offset_r <= i_cfg_row_early_warning[3:0];
      end
      else
      begin
         if (sync_issue && (sync_addr == `OFS_CONTROL) && !permanent_run_lock_r)
         begin
            enable_r <= sync_data[`CTRL_ENABLE_BIT];
            // window mode only changes while stopped; the lock only ever sets
            if (!enable_r)
            begin
               window_en_r <= sync_data[`CTRL_WINDOW_BIT];
            end
            permanent_run_lock_r <= sync_data[`CTRL_LOCK_BIT];
         end
         if (sync_issue && (sync_addr == `OFS_TIMING_SETUP) && setup_writable)
         begin
            window_select_r <= sync_data[7:4];
            timeout_period_select_r <= sync_data[3:0];
         end
         if (i_wr && (i_addr == `OFS_EARLY_WARNING_SETUP) && setup_writable)
         begin
            early_warning_offset_r <= i_wdata[3:0];
         end
      end
   end

   // sync tracking; a bus write landing while busy is held, the newest one winning
   always @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         sync_busy_r <= 1'b0;
         sync_cnt_r <= {`SYNC_CNT_W{1'b0}};
         held_valid_r <= 1'b0;
         held_addr_r <= {`ADDR_W{1'b0}};
         held_data_r <= `RST_BYTE;
      end
      else
      begin
         if (sync_issue)
         begin
            sync_busy_r <= 1'b1;
            sync_cnt_r <= `SYNC_CYCLES;
         end
         else if (sync_done)
         begin
            sync_busy_r <= 1'b0;
            sync_cnt_r <= {`SYNC_CNT_W{1'b0}};
         end
         else if (sync_busy_r)
         begin
            sync_cnt_r <= sync_cnt_r - {{(`SYNC_CNT_W-1){1'b0}}, 1'b1};
         end
         if (bus_sync_wr && (sync_busy_r || held_valid_r))
         begin
            held_valid_r <= 1'b1;
            held_addr_r <= i_addr;
            held_data_r <= i_wdata;
         end
         else if (sync_issue)
         begin
            held_valid_r <= 1'b0;
         end
      end
   end

   // interrupt enable and flag; a hardware set beats a same-cycle clear
   always @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         irq_enable_r <= `RST_IRQ_ENABLE;
         early_warning_bit_r <= `RST_IRQ_PENDING;
      end
      else
      begin
         if (wr_enable_on)
         begin
            irq_enable_r <= 1'b1;
         end
         else if (wr_enable_off)
         begin
            irq_enable_r <= 1'b0;
         end
         if (early_warning_event)
         begin
            early_warning_bit_r <= 1'b1;
         end
         else if (wr_pending_clear)
         begin
            early_warning_bit_r <= 1'b0;
         end
      end
   end

   // counter, outputs and read data
   always @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         tick_prev_r <= 1'b0;
         count_r <= {`LEN_W{1'b0}};
         open_phase_r <= 1'b0;
         o_rdata <= `RST_BYTE;
         o_irq <= 1'b0;
         o_sys_reset <= 1'b0;
         o_sync_pending <= 1'b0;
      end
      else
      begin
         tick_prev_r <= tick_level;
         count_r <= count_nxt;
         open_phase_r <= open_phase_nxt;
         o_rdata <= i_rd ? rdata_nxt : `RST_BYTE;
         o_irq <= early_warning_bit_r & irq_enable_r;
         // bad key, closed-window service and time-out all ask for a system reset
         o_sys_reset <= service_bad | closed_window_service | timeout_event;
         o_sync_pending <= sync_busy_r;
      end
   end

endmodule // wdt_window_watchdog

//--- tb/wdt_window_watchdog_properties.sv
/* concurrent checks on the watchdog register port, sync flag, interrupt and reset request.
   assumes only the top module's ports are visible; bound from tb_top. */
`timescale 1ns/100ps
`include "wdt_defines.vh"
module wdt_window_watchdog_properties (
   input wire i_clk_sys,
   input wire i_rst_n,
   input wire [`ADDR_W-1:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] o_rdata,
   input wire o_irq,
   input wire o_sys_reset,
   input wire o_sync_pending
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   wire sync_wr = i_wr && (i_addr == `OFS_CONTROL || i_addr == `OFS_TIMING_SETUP || i_addr == `OFS_SERVICE_KEY);
   sequence busy_hold;
      o_sync_pending [*4];
   endsequence
   sequence busy_gone;
      !o_sync_pending;
   endsequence
   sequence enable_set_then_read;
      i_wr && i_addr == `OFS_IRQ_ENABLE_ON && i_wdata[0] ##2 i_rd && i_addr inside {4'h4, 4'h5};
   endsequence
   chk_sync_starts: assert property (sync_wr |=> ##1 o_sync_pending)
      else $error("sync flag did not rise after synchronised write");
   chk_sync_span: assert property ($rose(o_sync_pending) |-> busy_hold ##[1:9] busy_gone)
      else $error("sync flag span wrong");
   chk_status_mirror: assert property (i_rd && i_addr == `OFS_SYNC_STATE |=> o_rdata == {o_sync_pending, 7'h00})
      else $error("status read disagrees with sync flag");
   chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   chk_enable_readback: assert property (enable_set_then_read |=> o_rdata[0])
      else $error("enable bit did not read back as set");
   chk_irq_disable: assert property (i_wr && i_addr == `OFS_IRQ_ENABLE_OFF && i_wdata[0] |=> ##1 !o_irq)
      else $error("irq stayed high after enable cleared");
   chk_flag_clear: assert property (i_wr && i_addr == `OFS_IRQ_PENDING && i_wdata[0] |-> ##2 !o_irq)
      else $error("irq stayed high after flag cleared");
   chk_bad_key: assert property (i_wr && i_addr == `OFS_SERVICE_KEY && i_wdata != `SERVICE_KEY_VALUE
      |-> ##[1:10] o_sys_reset)
      else $error("wrong service key gave no reset");
   chk_reset_pulse: assert property (o_sys_reset |=> !o_sys_reset)
      else $error("reset request longer than one cycle");
endmodule // wdt_window_watchdog_properties

//--- tb/tb_top.sv
/* self-checking bench for the windowed watchdog: bus tasks queue expectations, a monitor compares.
   assumes the defines header and the checker file are compiled before this file. */
`timescale 1ns/100ps
`include "wdt_defines.vh"
module tb_top;
   logic i_clk_sys;
   logic i_rst_n;
   logic i_watchdog_count_clock = 1'b0;
   logic [7:0] i_cfg_row_control;
   logic [7:0] i_cfg_row_timing;
   logic [7:0] i_cfg_row_early_warning;
   logic [`ADDR_W-1:0] i_addr;
   logic [7:0] i_wdata;
   logic i_wr;
   logic i_rd;
   wire [7:0] o_rdata;
   wire o_irq;
   wire o_sys_reset;
   wire o_sync_pending;
   logic [3:0] div = 4'h0;
   logic [7:0] ticks;
   logic pin_prev;
   logic irq_prev;
   logic rd_prev;
   logic [7:0] key;
   logic [31:0] seed;
   logic [7:0] rd_q[$];
   logic [8:0] evt_q[$];
   int failures;
   int checks;
   int cyc = 0;
   wdt_window_watchdog DUT (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_watchdog_count_clock(i_watchdog_count_clock),
      .i_cfg_row_control(i_cfg_row_control), .i_cfg_row_timing(i_cfg_row_timing),
      .i_cfg_row_early_warning(i_cfg_row_early_warning), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_sys_reset(o_sys_reset), .o_sync_pending(o_sync_pending));
   initial
   begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   task automatic final_report;
      if (failures == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic compare(input logic [8:0] exp, input logic [8:0] act);
      checks++;
      if (act !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, act);
      end
   endtask
   // count clock of 16 system cycles keeps every pin edge well clear of the service writes
   always @(posedge i_clk_sys)
   begin
      div <= div + 4'h1;
      i_watchdog_count_clock <= div[3];
      cyc <= cyc + 1;
      if (cyc == 9000)
      begin
         failures++;
         final_report();
      end
   end
   // falling edge sampling: outputs settled, no race with the driver
   always @(negedge i_clk_sys)
   begin
      if (rd_prev)
         compare(rd_q.size() ? {1'b0, rd_q.pop_front()} : 9'h1ff, {1'b0, o_rdata});
      if (o_sys_reset || (o_irq && !irq_prev))
      begin
         compare(evt_q.size() ? evt_q.pop_front() : 9'h1ff, {o_irq && !irq_prev, ticks});
         ticks = 8'h00;
      end
      else if (i_watchdog_count_clock && !pin_prev)
         ticks = ticks + 8'h01;
      rd_prev = i_rd;
      irq_prev = o_irq;
      pin_prev = i_watchdog_count_clock;
   end
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      if (wr && a == `OFS_SERVICE_KEY)
         ticks = 8'h00;
      i_wr <= wr;
      i_rd <= ~wr;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      @(posedge i_clk_sys);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      rd_q.push_back(exp);
      bus(1'b0, a, 8'h00);
   endtask
   task automatic wait_sync;
      repeat (3) @(posedge i_clk_sys);
      while (o_sync_pending)
         @(posedge i_clk_sys);
   endtask
   task automatic service_after_fall(input logic [7:0] d);
      @(negedge i_watchdog_count_clock);
      @(posedge i_clk_sys);
      bus(1'b1, `OFS_SERVICE_KEY, d);
   endtask
   task automatic take_irq;
      while (!o_irq)
         @(posedge i_clk_sys);
      rd(`OFS_IRQ_PENDING, 8'h01);
      bus(1'b1, `OFS_IRQ_PENDING, 8'hfe);
      rd(`OFS_IRQ_PENDING, 8'h01);
      bus(1'b1, `OFS_IRQ_PENDING, 8'h01);
      rd(`OFS_IRQ_PENDING, 8'h00);
   endtask
   task automatic drain;
      while (evt_q.size() != 0)
         @(posedge i_clk_sys);
   endtask
   initial
   begin
      seed = $urandom(32'hf882_85f4);
      i_rst_n = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 4'h0;
      i_wdata = 8'h00;
      ticks = 8'h00;
      pin_prev = 1'b0;
      irq_prev = 1'b0;
      rd_prev = 1'b0;
      failures = 0;
      checks = 0;
      i_cfg_row_control = 8'h00;
      i_cfg_row_timing = {4'($urandom_range(4'hb)), 4'($urandom_range(4'hb))};
      i_cfg_row_early_warning = {4'h0, 4'($urandom_range(4'hb))};
      key = 8'($urandom_range(8'hff));
      if (key == `SERVICE_KEY_VALUE)
         key = 8'h00;
      repeat (2) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      rd(`OFS_CONTROL, 8'h00);
      rd(`OFS_TIMING_SETUP, i_cfg_row_timing);
      rd(`OFS_EARLY_WARNING_SETUP, i_cfg_row_early_warning);
      rd(4'h3, 8'h00);
      rd(`OFS_SERVICE_KEY, 8'h00);
      rd(`OFS_IRQ_ENABLE_ON, 8'h00);
      bus(1'b1, `OFS_IRQ_ENABLE_ON, 8'hfe);
      rd(`OFS_IRQ_ENABLE_OFF, 8'h00);
      bus(1'b1, `OFS_IRQ_ENABLE_ON, 8'h01);
      rd(`OFS_IRQ_ENABLE_OFF, 8'h01);
      bus(1'b1, `OFS_IRQ_ENABLE_OFF, 8'hfe);
      rd(`OFS_IRQ_ENABLE_ON, 8'h01);
      bus(1'b1, `OFS_IRQ_ENABLE_OFF, 8'h01);
      rd(`OFS_IRQ_ENABLE_ON, 8'h00);
      bus(1'b1, `OFS_IRQ_ENABLE_ON, 8'h01);
      bus(1'b1, `OFS_TIMING_SETUP, 8'h01);
      wait_sync;
      bus(1'b1, `OFS_EARLY_WARNING_SETUP, 8'h00);
      rd(`OFS_TIMING_SETUP, 8'h01);
      bus(1'b1, `OFS_CONTROL, 8'h02);
      rd(`OFS_SYNC_STATE, 8'h80);
      wait_sync;
      rd(`OFS_SYNC_STATE, 8'h00);
      service_after_fall(`SERVICE_KEY_VALUE);
      repeat (2)
      begin
         evt_q.push_back(9'h108);
         take_irq;
         evt_q.push_back(9'h008);
         drain;
      end
      bus(1'b1, `OFS_CONTROL, 8'h00);
      wait_sync;
      bus(1'b1, `OFS_TIMING_SETUP, 8'h10);
      wait_sync;
      bus(1'b1, `OFS_CONTROL, 8'h06);
      wait_sync;
      evt_q.push_back(9'h000);
      service_after_fall(`SERVICE_KEY_VALUE);
      drain;
      evt_q.push_back(9'h110);
      take_irq;
      service_after_fall(`SERVICE_KEY_VALUE);
      evt_q.push_back(9'h110);
      take_irq;
      evt_q.push_back(9'h008);
      drain;
      evt_q.push_back(9'h000);
      service_after_fall(key);
      drain;
      bus(1'b1, `OFS_CONTROL, 8'h86);
      wait_sync;
      bus(1'b1, `OFS_CONTROL, 8'h00);
      wait_sync;
      bus(1'b1, `OFS_TIMING_SETUP, 8'hff);
      rd(`OFS_CONTROL, 8'h86);
      rd(`OFS_TIMING_SETUP, 8'h10);
      repeat (4) @(posedge i_clk_sys);
      // second reset with a different configuration row: the lock must fall and the new row load
      i_rst_n <= 1'b0;
      i_cfg_row_control <= 8'h02;
      i_cfg_row_timing <= 8'h3b;
      i_cfg_row_early_warning <= 8'h05;
      repeat (2) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      rd(`OFS_CONTROL, 8'h02);
      rd(`OFS_TIMING_SETUP, 8'h3b);
      rd(`OFS_EARLY_WARNING_SETUP, 8'h05);
      rd(`OFS_SYNC_STATE, 8'h00);
      repeat (4) @(posedge i_clk_sys);
      final_report();
   end
endmodule // tb_top
bind wdt_window_watchdog wdt_window_watchdog_properties chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
   .o_sys_reset(o_sys_reset), .o_sync_pending(o_sync_pending));
